// ==== hw/rmpu_pkg.sv ====
// package: register map, field layout and carrier types for the region protection unit
package rmpu_pkg;
  localparam int NUM_REGIONS = 8;
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_STATUS   = 12'h004;
  localparam logic [11:0] OFF_MASK     = 12'h008;
  localparam logic [11:0] OFF_FADDR    = 12'h00C;
  localparam logic [11:0] OFF_RGN_BASE = 12'h040;
  localparam logic [11:0] OFF_RGN_ATTR = 12'h080;
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_DEF_BIT  = 1;
  localparam int ATTR_EN_BIT   = 0;
  localparam int ATTR_SIZE_LSB = 1;
  localparam int ATTR_AP_LSB   = 8;
  localparam int ATTR_XN_BIT   = 12;
  localparam int STAT_MISS_BIT = 0;
  localparam int STAT_PERM_BIT = 1;
  localparam logic [4:0]  SIZE_MIN    = 5'h04;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] BASE_RST    = 32'h0000_0000;
  localparam logic [31:0] ATTR_RST    = 32'h0000_0000;
  localparam logic [1:0]  STAT_RST    = 2'h0;
  localparam logic [1:0]  MASK_RST    = 2'h0;
  localparam logic [2:0] AP_NONE_NONE = 3'h0;
  localparam logic [2:0] AP_RW_NONE   = 3'h1;
  localparam logic [2:0] AP_RW_RO     = 3'h2;
  localparam logic [2:0] AP_RW_RW     = 3'h3;
  localparam logic [2:0] AP_RO_NONE   = 3'h5;
  localparam logic [2:0] AP_RO_RO     = 3'h6;

  typedef enum logic [1:0] {RMPU_OP_READ, RMPU_OP_WRITE, RMPU_OP_EXEC} rmpu_op_e;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    rmpu_op_e    op;
    logic        priv;
  } rmpu_acc_s;

  typedef struct packed {
    logic        en;
    logic [4:0]  size;
    logic [2:0]  ap;
    logic        xn;
  } rmpu_attr_s;
endpackage

// ==== hw/rmpu_top.sv ====
// region protection unit: access checker, apb register file, fault interrupt
// Overview of operation
// - overlap allowed, region 7 highest priority
// - global enable plus eight configurable regions
// - highest enabled matching region decides rights
// - no region match uses default region
// - default bit: privileged allowed or all denied
// - read, write, execute checked per privilege
// - selected region permission matrix lookup
// - denied access signals violation to processor
// - misses and violations raise management fault
// - none/none faults all; rw/none privileged only
// - rw/ro faults user writes; rw/rw full
// - ro/none privileged reads; ro/ro reads only
// - privileged may access user-accessible regions
// - user refused in privileged-only regions
// - restrictive attribute values after reset; ctrl resets with the unit disabled, so every access is granted
// - only privileged writes change attributes
// - checked per access; denied access blocked
//
// Local design decisions: the APB interface to the registers and the address map.
module rmpu_top (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire rmpu_pkg::rmpu_acc_s acc,
  output logic                    acc_grant,
  output logic                    acc_deny,
  output logic                    memory_management_fault,
  output logic                    irq,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [2:0]         pprot,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr
);
  localparam int N = rmpu_pkg::NUM_REGIONS;

  // register map, one aligned word each:
  //   ctrl    bit0 unit enable, bit1 default region lets privileged through
  //   status  bit0 region miss, bit1 permission fault; read clears
  //   mask    same layout as status, selects what drives irq
  //   faddr   address of the most recent denied access
  //   base n  region start, low five bits forced to zero
  //   attr n  bit0 enable, size field, permission code, execute-never bit
  // limitation: a base that is not aligned to the region size is still
  // masked down, so the region covers the aligned block around it
  // access path timing: the request is judged combinationally and the
  // answer is registered, so grant, deny and fault stand one cycle after
  // the request and for exactly one cycle per request cycle
  // trade-off: one extra cycle of latency buys outputs straight from flops

  logic [31:0] ctrl_reg;
  logic [31:0] base_reg [N];
  logic [31:0] attr_reg [N];
  logic [1:0]  status_reg;
  logic [1:0]  mask_reg;
  logic [31:0] faddr_reg;

  // permission codes, privileged rights first, user rights second:
  //   none/none, rw/none, rw/ro, rw/rw, ro/none, ro/ro
  // codes 4 and 7 are unassigned and deny everything, which keeps a
  // corrupted code on the safe side
  // rights for one permission code, one operation and one privilege level
  function automatic logic ap_allows(input logic [2:0] ap, input logic priv,
                                     input logic wr);
    logic ok;
    ok = 1'b0;
    case (ap)
      rmpu_pkg::AP_NONE_NONE: ok = 1'b0;
      rmpu_pkg::AP_RW_NONE:   ok = priv;
      rmpu_pkg::AP_RW_RO:     ok = priv | ~wr;
      rmpu_pkg::AP_RW_RW:     ok = 1'b1;
      rmpu_pkg::AP_RO_NONE:   ok = priv & ~wr;
      rmpu_pkg::AP_RO_RO:     ok = ~wr;
      default:                ok = 1'b0;
    endcase
    return ok;
  endfunction

  // region size field s covers 2^(s+1) bytes, aligned on the base; s below 4 counts as 4, so at least 32 bytes
  function automatic logic in_region(input logic [31:0] a, input logic [31:0] base,
                                     input logic [4:0] size);
    logic [31:0] m;
    logic [4:0]  s;
    s = (size < rmpu_pkg::SIZE_MIN) ? rmpu_pkg::SIZE_MIN : size;
    m = (s == 5'h1F) ? 32'h0000_0000 : (32'hFFFF_FFFF << (s + 5'h01));
    return (a & m) == (base & m);
  endfunction

  // unpack one attribute word; the struct is narrower than the word
  function automatic rmpu_pkg::rmpu_attr_s attr_decode(input logic [31:0] w);
    rmpu_pkg::rmpu_attr_s f;
    f      = '0;
    f.en   = w[rmpu_pkg::ATTR_EN_BIT];
    f.size = w[rmpu_pkg::ATTR_SIZE_LSB +: 5];
    f.ap   = w[rmpu_pkg::ATTR_AP_LSB +: 3];
    f.xn   = w[rmpu_pkg::ATTR_XN_BIT];
    return f;
  endfunction

  // default region: privileged only when the bit is set, nothing otherwise
  function automatic logic default_allows(input logic def_bit, input logic priv);
    return def_bit & priv;
  endfunction

  rmpu_pkg::rmpu_attr_s sel_attr;
  logic                 hit;
  logic                 allow;
  logic                 is_wr;
  logic                 is_ex;
  logic                 miss_ev;
  logic                 perm_ev;

  logic [N-1:0]         rgn_hit;
  rmpu_pkg::rmpu_attr_s rgn_attr [N];
  logic [2:0]           win_idx;

  // every enabled region compares the address on its own
  always_comb begin
    rgn_hit = '0;
    for (int i = 0; i < N; i++) begin
      rgn_attr[i] = attr_decode(attr_reg[i]);
      rgn_hit[i]  = rgn_attr[i].en & in_region(acc.addr, base_reg[i], rgn_attr[i].size);
    end
  end

  // fixed priority: the highest matching index wins
  function automatic logic [2:0] top_index(input logic [7:0] v);
    logic [2:0] k;
    k = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        k = 3'(i);
      end
    end
    return k;
  endfunction

  always_comb begin
    hit      = |rgn_hit;
    win_idx  = top_index(rgn_hit);
    sel_attr = rgn_attr[win_idx];
  end

  always_comb begin
    is_wr = (acc.op == rmpu_pkg::RMPU_OP_WRITE);
    is_ex = (acc.op == rmpu_pkg::RMPU_OP_EXEC);
  end

  always_comb begin
    if (!ctrl_reg[rmpu_pkg::CTRL_EN_BIT]) begin
      allow = 1'b1;
    end else if (hit) begin
      // execute needs read rights and no execute-never
      allow = ap_allows(sel_attr.ap, acc.priv, is_wr) & ~(is_ex & sel_attr.xn);
    end else begin
      allow = default_allows(ctrl_reg[rmpu_pkg::CTRL_DEF_BIT], acc.priv);
    end
  end

  // a miss is a denial with no matching region, anything else is permission
  always_comb begin
    miss_ev = acc.valid & ~allow & ~hit;
    perm_ev = acc.valid & ~allow & hit;
  end

  // answer registered one cycle after the request; memory must gate on grant
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_grant <= 1'b0;
    end else begin
      acc_grant <= acc.valid & allow;
    end
  end

  // a denied access never reaches memory, it only reports
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_deny <= 1'b0;
    end else begin
      acc_deny <= acc.valid & ~allow;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      memory_management_fault <= 1'b0;
    end else begin
      memory_management_fault <= miss_ev | perm_ev;
    end
  end

  // faulting address holds until the next denial; reads leave it alone

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      faddr_reg <= 32'h0000_0000;
    end else if (miss_ev | perm_ev) begin
      faddr_reg <= acc.addr;
    end
  end

  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic priv_wr;
  logic in_base;
  logic in_attr;
  logic [2:0] ridx;
  logic mapped;
  logic sel_ctrl;
  logic sel_status;
  logic sel_mask;
  logic sel_faddr;
  logic [1:0] stat_seen_reg;
  logic [31:0] rd_word;

  // register side: decode is settled during setup, so pslverr and read
  // data can be registered there and stand with pready in the access phase
  always_comb begin
    apb_acc = psel & penable;
    apb_wr  = apb_acc & pwrite;
    apb_rd  = apb_acc & ~pwrite;
    priv_wr = apb_wr & pprot[0];
    in_base = (paddr[11:5] == rmpu_pkg::OFF_RGN_BASE[11:5]);
    in_attr = (paddr[11:5] == rmpu_pkg::OFF_RGN_ATTR[11:5]);
    ridx    = paddr[4:2];
    // only pprot[0] matters: the other protection flags do not gate writes
    sel_ctrl   = (paddr == rmpu_pkg::OFF_CTRL);
    sel_status = (paddr == rmpu_pkg::OFF_STATUS);
    sel_mask   = (paddr == rmpu_pkg::OFF_MASK);
    sel_faddr  = (paddr == rmpu_pkg::OFF_FADDR);
    if (paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (paddr == rmpu_pkg::OFF_CTRL || paddr == rmpu_pkg::OFF_STATUS) begin
      mapped = 1'b1;
    end else if (paddr == rmpu_pkg::OFF_MASK || paddr == rmpu_pkg::OFF_FADDR) begin
      mapped = 1'b1;
    end else begin
      mapped = in_base | in_attr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= rmpu_pkg::CTRL_RST;
    end else if (priv_wr && sel_ctrl) begin
      ctrl_reg <= {30'h0, pwdata[1:0]};
    end
  end

  // mask bits follow the status layout
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_reg <= rmpu_pkg::MASK_RST;
    end else if (priv_wr && sel_mask) begin
      mask_reg <= pwdata[1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < N; i++) begin
        base_reg[i] <= rmpu_pkg::BASE_RST;
      end
    end else if (priv_wr && mapped && in_base) begin
      base_reg[ridx] <= {pwdata[31:5], 5'h00};
    end
  end

  // reserved attribute bits up to bit 12 are kept as written, bits 31:13 are cleared; only decoded fields act
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < N; i++) begin
        attr_reg[i] <= rmpu_pkg::ATTR_RST;
      end
    end else if (priv_wr && mapped && in_attr) begin
      attr_reg[ridx] <= {19'h0, pwdata[12:0]};
    end
  end

  // bits shown to the reader at setup; only those are cleared at access
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_seen_reg <= rmpu_pkg::STAT_RST;
    end else if (psel && !penable && !pwrite && sel_status) begin
      stat_seen_reg <= status_reg;
    end
  end

  // event wins over the read that clears it; an event between setup and
  // access was never shown, so it survives the clear as well
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_reg <= rmpu_pkg::STAT_RST;
    end else if (apb_rd && sel_status) begin
      status_reg <= (status_reg & ~stat_seen_reg) | {perm_ev, miss_ev};
    end else begin
      status_reg <= status_reg | {perm_ev, miss_ev};
    end
  end

  // level output, one cycle behind the status bits

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // read mux, settled during the setup cycle
  always_comb begin
    rd_word = 32'h0000_0000;
    if (!mapped) begin
      rd_word = 32'h0000_0000;
    end else if (sel_ctrl) begin
      rd_word = ctrl_reg;
    end else if (sel_status) begin
      rd_word = {30'h0, status_reg};
    end else if (sel_mask) begin
      rd_word = {30'h0, mask_reg};
    end else if (sel_faddr) begin
      rd_word = faddr_reg;
    end else if (in_base) begin
      rd_word = base_reg[ridx];
    end else begin
      rd_word = attr_reg[ridx];
    end
  end

  // zero-wait slave: pready answers in the access phase itself
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
    end
  end

  // unmapped or misaligned addresses are refused, writes there dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  // data taken at setup so it stands with pready; zero outside reads
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end
endmodule

// ==== testbench/rmpu_core_model.sv ====
// core model: register traffic at either privilege level and memory accesses
module rmpu_core_model (
  input  wire logic           ref_clk,
  input  wire logic           pready,
  input  wire logic [31:0]    prdata,
  output rmpu_pkg::rmpu_acc_s acc,
  output logic                psel,
  output logic                penable,
  output logic                pwrite,
  output logic [11:0]         paddr,
  output logic [31:0]         pwdata,
  output logic [2:0]          pprot
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    acc = '0;
    {psel, penable, pwrite, paddr, pwdata, pprot} = '0;
  end
  // request held until pready; released data is scrambled, never left stale
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic pv, output logic [31:0] q);
    logic rdy;
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    pprot <= {2'b00, pv};
    @(posedge ref_clk);
    penable <= 1'b1;
    // outputs move only on rising edges: the falling-edge value is the one
    // sampled at the next rising edge
    do begin
      @(negedge ref_clk);
      rdy = pready;
      q = prdata;
      @(posedge ref_clk);
    end while (rdy !== 1'b1);
    {psel, penable} <= 2'b00;
    pwdata <= ~d;
  endtask
  task automatic go(input logic [31:0] a, input rmpu_pkg::rmpu_op_e op, input logic pv);
    @(posedge ref_clk);
    acc <= '{1'b1, a, op, pv};
    @(posedge ref_clk);
    acc.valid <= 1'b0;
    acc.addr <= ~a;
  endtask
endmodule

// ==== testbench/rmpu_checker.sv ====
// checker: port-level properties of the region protection unit
module rmpu_checker (
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire rmpu_pkg::rmpu_acc_s acc,
  input wire logic                acc_grant,
  input wire logic                acc_deny,
  input wire logic                memory_management_fault,
  input wire logic                irq,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [2:0]          pprot,
  input wire logic                pready,
  input wire logic                pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en_reg;
  wire  ctrl_wr = psel && penable && pready && pwrite && pprot[0] && paddr == 12'h000;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // own copy of the enable; user writes must not move it
  always_ff @(posedge ref_clk) begin
    if (rst) en_reg <= 1'b0;
    else if (ctrl_wr) en_reg <= pwdata[rmpu_pkg::CTRL_EN_BIT];
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  property p_answer; acc.valid |=> acc_grant != acc_deny; endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_idle; !acc.valid |=> !acc_grant && !acc_deny; endproperty
  a_idle: assert property (p_idle) else $error("answer without access");
  property p_fault; memory_management_fault == acc_deny; endproperty
  a_fault: assert property (p_fault) else $error("fault and deny differ");
  property p_off; !en_reg && acc.valid |=> acc_grant; endproperty
  a_off: assert property (p_off) else $error("disabled unit denied");
  property p_irq; $rose(irq) |-> $past(acc_deny); endproperty
  a_irq: assert property (p_irq) else $error("irq without fault");
  property p_wait; s_setup ##1 s_access |-> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_rdy; pready |-> psel && penable; endproperty
  a_rdy: assert property (p_rdy) else $error("pready outside access");
  property p_unmap; s_access ##0 (paddr == 12'hFFC) |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
endmodule
bind rmpu_top rmpu_checker u_chk (.ref_clk(ref_clk), .rst(rst), .acc(acc),
  .acc_grant(acc_grant), .acc_deny(acc_deny), .irq(irq),
  .memory_management_fault(memory_management_fault), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .pready(pready),
  .pslverr(pslverr));

// ==== testbench/tb_top.sv ====
// self-checking bench for the region protection unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                ref_clk = 1'b0;
  logic                rst = 1'b1;
  logic                acc_grant, acc_deny, memory_management_fault, irq;
  logic                psel, penable, pwrite, pready, pslverr;
  logic [2:0]          pprot;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, q;
  rmpu_pkg::rmpu_acc_s acc;
  int                  num_errors = 0;
  int                  total_checks = 0;
  always #4 ref_clk = ~ref_clk;
  rmpu_core_model core (.ref_clk(ref_clk), .pready(pready), .prdata(prdata), .acc(acc),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pprot(pprot));
  rmpu_top uut (.ref_clk(ref_clk), .rst(rst), .acc(acc), .acc_grant(acc_grant),
    .acc_deny(acc_deny), .memory_management_fault(memory_management_fault), .irq(irq),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    core.xfer(1'b1, a, d, 1'b1, q);
  endtask
  task automatic rd(input logic [11:0] a);
    core.xfer(1'b0, a, 32'h0000_0000, 1'b1, q);
  endtask
  task automatic probe(input logic [31:0] a, input rmpu_pkg::rmpu_op_e op, input logic pv,
                       input logic ok);
    core.go(a, op, pv);
    #1;
    check(32'({acc_grant, acc_deny, memory_management_fault}), 32'({ok, !ok, !ok}));
  endtask
  // every region sits on the same 32-byte block to force overlap
  task automatic region(input logic [2:0] n, input logic [2:0] ap, input logic xn);
    wr(rmpu_pkg::OFF_RGN_BASE + {7'h00, n, 2'b00}, 32'h0000_1000);
    wr(rmpu_pkg::OFF_RGN_ATTR + {7'h00, n, 2'b00},
       {19'h0, xn, 1'b0, ap, 2'b00, rmpu_pkg::SIZE_MIN, 1'b1});
  endtask
  task automatic t_reset();
    rd(rmpu_pkg::OFF_CTRL);
    check(q, rmpu_pkg::CTRL_RST);
    rd(rmpu_pkg::OFF_RGN_ATTR + 12'h01C);
    check(q, rmpu_pkg::ATTR_RST);
    probe(32'h0000_1000, rmpu_pkg::RMPU_OP_WRITE, 1'b0, 1'b1);
  endtask
  task automatic t_default();
    wr(rmpu_pkg::OFF_CTRL, 32'h0000_0001);
    probe(32'h0000_2000, rmpu_pkg::RMPU_OP_READ, 1'b1, 1'b0);
    wr(rmpu_pkg::OFF_CTRL, 32'h0000_0003);
    probe(32'h0000_2000, rmpu_pkg::RMPU_OP_READ, 1'b1, 1'b1);
    probe(32'h0000_2000, rmpu_pkg::RMPU_OP_READ, 1'b0, 1'b0);
    core.xfer(1'b1, rmpu_pkg::OFF_CTRL, 32'h0000_0001, 1'b0, q);
    probe(32'h0000_2000, rmpu_pkg::RMPU_OP_WRITE, 1'b1, 1'b1);
    wr(rmpu_pkg::OFF_CTRL, 32'h0000_0001);
  endtask
  task automatic t_perm();
    logic [2:0] code [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
    logic [3:0] pm [6] = '{4'h0, 4'hC, 4'hE, 4'hF, 4'h8, 4'hA};
    for (int i = 0; i < 6; i++) begin
      region(3'h0, code[i], 1'b0);
      for (int j = 0; j < 4; j++) begin
        probe(32'h0000_1010, j[0] ? rmpu_pkg::RMPU_OP_WRITE : rmpu_pkg::RMPU_OP_READ,
              !j[1], pm[i][3 - j]);
      end
    end
    probe(32'h0000_1020, rmpu_pkg::RMPU_OP_READ, 1'b1, 1'b0);
    region(3'h0, 3'h3, 1'b1);
    probe(32'h0000_1000, rmpu_pkg::RMPU_OP_EXEC, 1'b1, 1'b0);
    region(3'h0, 3'h3, 1'b0);
    probe(32'h0000_1000, rmpu_pkg::RMPU_OP_EXEC, 1'b0, 1'b1);
  endtask
  task automatic t_overlap();
    region(3'h7, 3'h6, 1'b0);
    region(3'h3, 3'h1, 1'b0);
    probe(32'h0000_1000, rmpu_pkg::RMPU_OP_READ, 1'b0, 1'b1);
    wr(rmpu_pkg::OFF_RGN_ATTR + 12'h01C, 32'h0000_0000);
    probe(32'h0000_1000, rmpu_pkg::RMPU_OP_READ, 1'b0, 1'b0);
  endtask
  task automatic t_irq();
    rd(rmpu_pkg::OFF_STATUS);
    probe(32'h0000_8000, rmpu_pkg::RMPU_OP_READ, 1'b1, 1'b0);
    repeat (2) @(posedge ref_clk);
    #1;
    check({31'h0, irq}, 32'h0000_0000);
    rd(rmpu_pkg::OFF_STATUS);
    wr(rmpu_pkg::OFF_MASK, 32'h0000_0003);
    probe(32'h0000_8000, rmpu_pkg::RMPU_OP_READ, 1'b1, 1'b0);
    probe(32'h0000_1000, rmpu_pkg::RMPU_OP_WRITE, 1'b0, 1'b0);
    repeat (2) @(posedge ref_clk);
    #1;
    check({31'h0, irq}, 32'h0000_0001);
    rd(rmpu_pkg::OFF_STATUS);
    check(q, 32'h0000_0003);
    @(posedge ref_clk);
    #1;
    check({31'h0, irq}, 32'h0000_0000);
    rd(rmpu_pkg::OFF_FADDR);
    check(q, 32'h0000_1000);
    rd(12'hFFC);
    check(q, 32'h0000_0000);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_default();
    t_perm();
    t_overlap();
    t_irq();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    print_verdict();
  end
endmodule
